// ---- rtl/lwcr_top.sv ----
// sideband wake and reference clock request logic for a single lane endpoint
// Operation
// - wake request is pulled low when a wake packet arrives with either wake enable bit set.
// - in normal link operation the clock request pin is held low.
// - in L1 or L2 the clock request pin is released.
// - the link pll makes 125 MHz and 250 MHz core clocks from the reference clock.
// - a released open-drain line is not trusted low until the pull-up settles.
`timescale 1ns/1ps
`include "lwcr_defines.svh"
module lwcr_top #(
  parameter int unsigned SETTLE_CYCLES = `LWCR_RELEASE_SETTLE_CYCLES,
  parameter int unsigned REFCLK_WAIT   = `LWCR_REFCLK_WAIT_CYCLES
) (
  input  wire logic                      clk_sys_in,
  input  wire logic                      sys_rst_in,
  input  wire logic                      link_reset_n_in,
  input  wire logic                      wake_packet_in,
  input  wire lwcr_pkg::lwcr_wake_cfg_t  wake_cfg_in,
  input  wire logic                      wake_clear_in,
  input  wire lwcr_pkg::lwcr_link_state_t link_state_in,
  input  wire logic                      l1_exit_request_in,
  input  wire logic                      refclk_present_in,
  input  wire logic                      wake_request_n_in,
  input  wire logic                      refclk_request_n_in,
  output logic                           wake_request_n_out,
  output logic                           wake_request_n_oe_n_out,
  output logic                           refclk_request_n_out,
  output logic                           refclk_request_n_oe_n_out,
  output logic                           l1_exit_grant_out,
  output logic                           link_power_ok_out,
  output logic                           wake_line_low_out,
  output logic                           refclk_line_low_out
);
  // ==========================================================
  // pin input synchronisers
  // ==========================================================
  logic [2:0] rst_sync;
  logic [2:0] wake_sync;
  logic [2:0] creq_sync;
  logic [2:0] rclk_sync;
  logic       link_power_ok;
  logic       wake_line_low;
  logic       creq_line_low;
  logic       refclk_ok;

  // three stage sampling of pins
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rst_sync  <= 3'h0;
      wake_sync <= 3'h7;
      creq_sync <= 3'h7;
      rclk_sync <= 3'h0;
    end else begin
      rst_sync  <= {rst_sync[1:0], link_reset_n_in};
      wake_sync <= {wake_sync[1:0], wake_request_n_in};
      creq_sync <= {creq_sync[1:0], refclk_request_n_in};
      rclk_sync <= {rclk_sync[1:0], refclk_present_in};
    end
  end

  // accept a level once stages two and three agree
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      link_power_ok <= 1'b0;
      wake_line_low <= 1'b0;
      creq_line_low <= 1'b0;
      refclk_ok     <= 1'b0;
    end else begin
      if (rst_sync[1] == rst_sync[2]) link_power_ok <= rst_sync[2];
      if (wake_sync[1] == wake_sync[2]) wake_line_low <= ~wake_sync[2];
      if (creq_sync[1] == creq_sync[2]) creq_line_low <= ~creq_sync[2];
      if (rclk_sync[1] == rclk_sync[2]) refclk_ok <= rclk_sync[2];
    end
  end

  // ==========================================================
  // wake request
  // ==========================================================
  logic wake_pending;
  logic wake_enabled;
  assign wake_enabled = wake_cfg_in.pme_enable | wake_cfg_in.apm_wake_enable;

  // sticky wake, set wins over clear
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wake_pending <= 1'b0;
    end else if (wake_packet_in && wake_enabled) begin
      wake_pending <= 1'b1;
    end else if (wake_clear_in) begin
      wake_pending <= 1'b0;
    end
  end

  // ==========================================================
  // clock request state machine
  // ==========================================================
  lwcr_pkg::lwcr_refclk_request_n_state_t cr_state;
  lwcr_pkg::lwcr_refclk_request_n_state_t next_cr_state;
  logic [7:0] wait_cnt;
  logic       in_idle;
  assign in_idle = (link_state_in == lwcr_pkg::LWCR_LINK_L1) ||
                   (link_state_in == lwcr_pkg::LWCR_LINK_L2);

  // next state
  always_comb begin
    next_cr_state = cr_state;
    unique case (cr_state)
      lwcr_pkg::LWCR_CR_ACTIVE: begin
        if (in_idle) next_cr_state = lwcr_pkg::LWCR_CR_IDLE;
      end
      lwcr_pkg::LWCR_CR_IDLE: begin
        if (l1_exit_request_in || !in_idle) next_cr_state = lwcr_pkg::LWCR_CR_WAKING;
      end
      lwcr_pkg::LWCR_CR_WAKING: begin
        if (refclk_ok && wait_cnt >= 8'(REFCLK_WAIT)) begin
          next_cr_state = lwcr_pkg::LWCR_CR_ACTIVE;
        end
      end
      default: next_cr_state = lwcr_pkg::LWCR_CR_ACTIVE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cr_state <= lwcr_pkg::LWCR_CR_ACTIVE;
    end else begin
      cr_state <= next_cr_state;
    end
  end

  // clock presence wait counter
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || cr_state != lwcr_pkg::LWCR_CR_WAKING || !refclk_ok) begin
      wait_cnt <= 8'h00;
    end else if (wait_cnt < 8'(REFCLK_WAIT)) begin
      wait_cnt <= wait_cnt + 8'h01;
    end
  end

  // ==========================================================
  // released line settle window
  // ==========================================================
  logic [3:0] wake_settle;
  logic [3:0] creq_settle;
  logic       wake_drive;
  logic       creq_drive;
  assign wake_drive = wake_pending;
  assign creq_drive = (cr_state != lwcr_pkg::LWCR_CR_IDLE);

  // mask line readback while pull-up restores the high level
  // window also spans the output flop and the synchroniser, else a stale low leaks out
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wake_settle <= 4'h0;
      creq_settle <= 4'h0;
    end else begin
      if (wake_drive) wake_settle <= 4'(SETTLE_CYCLES + `LWCR_READBACK_LAG_CYCLES);
      else if (wake_settle != 4'h0) wake_settle <= wake_settle - 4'h1;
      if (creq_drive) creq_settle <= 4'(SETTLE_CYCLES + `LWCR_READBACK_LAG_CYCLES);
      else if (creq_settle != 4'h0) creq_settle <= creq_settle - 4'h1;
    end
  end

  // ==========================================================
  // registered outputs
  // ==========================================================
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wake_request_n_oe_n_out   <= 1'b1;
      refclk_request_n_oe_n_out <= 1'b0;
      l1_exit_grant_out         <= 1'b0;
      link_power_ok_out         <= 1'b0;
      wake_line_low_out         <= 1'b0;
      refclk_line_low_out       <= 1'b1;
    end else begin
      wake_request_n_oe_n_out   <= ~wake_drive;
      refclk_request_n_oe_n_out <= ~creq_drive;
      l1_exit_grant_out         <= (next_cr_state == lwcr_pkg::LWCR_CR_ACTIVE) &&
                                   (cr_state == lwcr_pkg::LWCR_CR_WAKING);
      link_power_ok_out         <= link_power_ok;
      wake_line_low_out         <= wake_line_low & (wake_settle == 4'h0);
      refclk_line_low_out       <= creq_drive | (creq_line_low & (creq_settle == 4'h0));
    end
  end

  // open drain pins only ever pull low
  assign wake_request_n_out   = 1'b0;
  assign refclk_request_n_out = 1'b0;
endmodule

// ---- inc/lwcr_defines.svh ----
// constants for the link wake and clock request block
`ifndef LWCR_DEFINES_SVH
`define LWCR_DEFINES_SVH
`define LWCR_RELEASE_SETTLE_CYCLES 3'h3
`define LWCR_REFCLK_WAIT_CYCLES    4'h8
// extra cycles a released line still reads low: output flop plus input synchroniser
`define LWCR_READBACK_LAG_CYCLES   4'h5
`define LWCR_CORE_CLK_SLOW_MHZ     125
`define LWCR_CORE_CLK_FAST_MHZ     250
`endif

// ---- inc/lwcr_pkg.sv ----
// types for the link wake and clock request block
package lwcr_pkg;
  typedef enum logic [1:0] {
    LWCR_LINK_L0  = 2'h0,
    LWCR_LINK_L0S = 2'h1,
    LWCR_LINK_L1  = 2'h2,
    LWCR_LINK_L2  = 2'h3
  } lwcr_link_state_t;

  typedef struct packed {
    logic pme_enable;
    logic apm_wake_enable;
  } lwcr_wake_cfg_t;

  typedef enum logic [1:0] {
    LWCR_CR_ACTIVE  = 2'h0,
    LWCR_CR_IDLE    = 2'h1,
    LWCR_CR_WAKING  = 2'h2
  } lwcr_refclk_request_n_state_t;
endpackage

// ---- tb/lwcr_top_sva.sv ----
// checker for the link wake and clock request block
`timescale 1ns/1ps
module lwcr_chk #(parameter int unsigned REFCLK_WAIT = 8) (
  input wire logic                        clk_sys_in,
  input wire logic                        sys_rst_in,
  input wire logic                        link_reset_n_in,
  input wire logic                        wake_packet_in,
  input wire lwcr_pkg::lwcr_wake_cfg_t    wake_cfg_in,
  input wire lwcr_pkg::lwcr_link_state_t  link_state_in,
  input wire logic                        refclk_present_in,
  input wire logic                        wake_request_n_oe_n_out,
  input wire logic                        refclk_request_n_oe_n_out,
  input wire logic                        l1_exit_grant_out,
  input wire logic                        link_power_ok_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic [7:0] run;
  // ==========================================
  // cycles the reference clock has been present
  always_ff @(posedge clk_sys_in) begin
    run <= (sys_rst_in || !refclk_present_in) ? 8'h00 : run + {7'h00, run != 8'hFF};
  end
  a_wake_set: assert property (wake_packet_in && |wake_cfg_in |-> ##2 !wake_request_n_oe_n_out)
    else $error("wake request not driven");
  a_wake_cause: assert property ($fell(wake_request_n_oe_n_out) |-> $past(wake_packet_in, 2))
    else $error("wake request without packet");
  a_clk_release: assert property ($rose(refclk_request_n_oe_n_out) |-> $past(link_state_in[1], 2))
    else $error("clock request released outside idle");
  a_clk_normal: assert property (!link_state_in[1] |-> ##2 !refclk_request_n_oe_n_out)
    else $error("clock request not held low");
  a_grant_clock: assert property (l1_exit_grant_out |-> run >= REFCLK_WAIT && !refclk_request_n_oe_n_out)
    else $error("exit granted without clock");
  a_grant_pulse: assert property (l1_exit_grant_out |=> !l1_exit_grant_out)
    else $error("grant longer than one cycle");
  a_power_high: assert property (link_reset_n_in [*8] |-> link_power_ok_out)
    else $error("link power not reported");
  a_power_low: assert property (!link_reset_n_in [*8] |-> !link_power_ok_out)
    else $error("link power reported while absent");
  cover property (!wake_request_n_oe_n_out);
  cover property (refclk_request_n_oe_n_out);
  cover property (l1_exit_grant_out);
endmodule
bind lwcr_top lwcr_chk #(.REFCLK_WAIT(REFCLK_WAIT)) u_chk (.clk_sys_in, .sys_rst_in,
  .link_reset_n_in, .wake_packet_in, .wake_cfg_in, .link_state_in, .refclk_present_in,
  .wake_request_n_oe_n_out, .refclk_request_n_oe_n_out, .l1_exit_grant_out, .link_power_ok_out);

// ---- tb/lwcr_host.sv ----
// host platform model: pull-ups, reference clock driver and link reset
`timescale 1ns/1ps
module lwcr_host (
  input  wire logic clk_sys_in,
  input  wire logic wake_oe_n_in,
  input  wire logic refclk_request_n_oe_n_in,
  input  wire logic gate_in,
  input  wire logic power_in,
  output logic      wake_line_out,
  output logic      refclk_request_n_line_out,
  output logic      refclk_present_out,
  output logic      link_reset_n_out
);
  logic [1:0] wk, ck;
  // ==========================================
  // weak pull-up restores a released line two periods late
  always_ff @(posedge clk_sys_in) begin
    wk <= {wk[0], wake_oe_n_in};
    ck <= {ck[0], refclk_request_n_oe_n_in};
  end
  assign wake_line_out = wake_oe_n_in & wk[1];
  assign refclk_request_n_line_out = refclk_request_n_oe_n_in & ck[1];
  // clock gated when request line high and gating allowed, absent without power
  always_ff @(posedge clk_sys_in) refclk_present_out <= power_in && !(gate_in && refclk_request_n_line_out);
  assign link_reset_n_out = power_in;
endmodule

// ---- tb/test_link_wake_clock_request.sv ----
// self-checking bench for the link wake and clock request block
`timescale 1ns/1ps
module test_link_wake_clock_request;
  logic clk_sys_in, sys_rst_in, rst_n, pkt, clr, exit_req, present, wline, cline, gate, pwr;
  logic wake_oe, clk_oe, grant, pwr_ok, prev_oe, wline_low, cline_low;
  lwcr_pkg::lwcr_wake_cfg_t   cfg;
  lwcr_pkg::lwcr_link_state_t st;
  logic [1:0] ev;
  logic [1:0] exp_q[$];
  int n_mismatch, num_checks;
  logic [31:0] seed;
  lwcr_top dut (.clk_sys_in, .sys_rst_in, .link_reset_n_in(rst_n), .wake_packet_in(pkt),
    .wake_cfg_in(cfg), .wake_clear_in(clr), .link_state_in(st), .l1_exit_request_in(exit_req),
    .refclk_present_in(present), .wake_request_n_in(wline), .refclk_request_n_in(cline),
    .wake_request_n_out(), .wake_request_n_oe_n_out(wake_oe), .refclk_request_n_out(),
    .refclk_request_n_oe_n_out(clk_oe), .l1_exit_grant_out(grant), .link_power_ok_out(pwr_ok),
    .wake_line_low_out(wline_low), .refclk_line_low_out(cline_low));
  lwcr_host u_host (.clk_sys_in, .wake_oe_n_in(wake_oe), .refclk_request_n_oe_n_in(clk_oe), .gate_in(gate),
    .power_in(pwr), .wake_line_out(wline), .refclk_request_n_line_out(cline),
    .refclk_present_out(present), .link_reset_n_out(rst_n));
  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    n_mismatch++;
    finish_test();
  end
  // match each wake or grant event to the oldest note
  always @(negedge clk_sys_in) begin
    ev = (prev_oe === 1'b1 && wake_oe === 1'b0) ? 2'h0 : (grant === 1'b1 ? 2'h1 : 2'h3);
    if (!sys_rst_in && ev != 2'h3) check(ev, exp_q.size() ? exp_q.pop_front() : 2'h3);
    prev_oe = wake_oe;
  end
  // ==========================================
  // main sequence
  initial begin
    {sys_rst_in, pkt, clr, exit_req, gate, pwr, cfg, st, seed} = {6'h21, 4'h0, 32'h05BF315F};
    repeat (6) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(negedge clk_sys_in);
    check({1'b0, wake_oe}, 2'h1);
    check({1'b0, clk_oe}, 2'h0);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      @(posedge clk_sys_in);
      cfg <= i[1:0];
      st <= lwcr_pkg::lwcr_link_state_t'({1'b0, seed[0]});
      pkt <= 1'b1;
      if (i != 0) exp_q.push_back(2'h0);
      @(posedge clk_sys_in);
      pkt <= 1'b0;
      repeat (4) @(negedge clk_sys_in);
      check({1'b0, wake_oe}, {1'b0, i == 0});
      check({1'b0, clk_oe}, 2'h0);
      @(posedge clk_sys_in);
      clr <= 1'b1;
      @(posedge clk_sys_in);
      clr <= 1'b0;
      // released wake line must not read as low while the pull-up restores it
      repeat (6) @(negedge clk_sys_in);
      check({1'b0, wline_low}, 2'h0);
    end
    for (int s = 2; s < 4; s++) begin
      @(posedge clk_sys_in);
      gate <= 1'b1;
      st <= lwcr_pkg::lwcr_link_state_t'(s);
      repeat (6) @(negedge clk_sys_in);
      check({1'b0, clk_oe}, 2'h1);
      check({1'b0, cline_low}, 2'h0);
      @(posedge clk_sys_in);
      st <= lwcr_pkg::LWCR_LINK_L0;
      exit_req <= 1'b1;
      exp_q.push_back(2'h1);
      for (int k = 0; k < 64 && exp_q.size() != 0; k++) @(posedge clk_sys_in);
      exit_req <= 1'b0;
      @(negedge clk_sys_in);
      check({1'b0, clk_oe}, 2'h0);
      check({1'b0, cline_low}, 2'h1);
    end
    @(posedge clk_sys_in);
    pwr <= 1'b0;
    repeat (12) @(negedge clk_sys_in);
    check({1'b0, pwr_ok}, 2'h0);
    @(posedge clk_sys_in);
    pwr <= 1'b1;
    repeat (12) @(negedge clk_sys_in);
    check({1'b0, pwr_ok}, 2'h1);
    check(2'(exp_q.size()), 2'h0);
    finish_test();
  end
endmodule
